// ==== design/imct_pkg.sv ====
package imct_pkg;

    // Minimum spacings, in bus clock half periods (T)
    localparam int unsigned MEM_ADDR_HOLD_T   = 10;
    localparam int unsigned IO_ADDR_HOLD_T    = 19;
    localparam int unsigned CMD_TO_ALE_T      = 10;
    localparam int unsigned CMD_TO_CMD_T      = 12;
    localparam int unsigned NEG_TO_CMD_T      = 3;
    localparam int unsigned NEG_TO_ALE_T      = 1;
    localparam int unsigned ALE_WIDTH_T       = 1;
    localparam int unsigned ALE_TO_CMD_T      = 2;
    localparam int unsigned CMD_WIDTH_T       = 9;
    localparam int unsigned RDY_TO_NEG_T      = 1;
    localparam int unsigned RDY16_FROM_LA_T   = 8;
    localparam int unsigned RDY8_FROM_LA_T    = 14;
    localparam int unsigned RDY16_FROM_CMD_T  = 6;
    localparam int unsigned RDY8_FROM_CMD_T   = 12;

    // Reference clock ticks per T, half a bus clock period (doubled clock halved)
    localparam int unsigned TICKS_PER_T       = 2;
    localparam int unsigned CNT_W             = 6;

    // Reset values
    localparam logic [19:0] SA_RESET          = 20'h00000;
    localparam logic [6:0]  LA_RESET          = 7'h00;

    typedef enum logic [1:0] {
        IMCT_KIND_MEM,
        IMCT_KIND_SMEM,
        IMCT_KIND_IO
    } imct_kind_t;

endpackage

// ==== design/imct_cycle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Memory commands: SA held at least 10 T after command assertion.
// - I/O commands: SA held at least 19 T after command assertion.
// - Memory command assertion to next ALE at least 10 T.
// - Low-memory command assertion to next ALE at least 10 T.
// - I/O command assertion to next ALE at least 10 T.
// - Successive memory command assertions at least 12 T apart.
// - Successive low-memory command assertions at least 12 T apart.
// - Successive I/O command assertions at least 12 T apart.
// - Any command negation to memory command assertion at least 3 T.
// - Any command negation to I/O command assertion at least 3 T.
// - Memory command negation to next ALE at least 1 T.
// - Low-memory command negation to next ALE at least 1 T.
// - I/O command negation to next ALE at least 1 T.
// - Slave ready negation timed from LA valid: 8 T or 14 T.
// - Slave ready negation timed from command: 6 T or 12 T.
// - ALE held asserted at least 1 T.
module imct_cycle_timer
    import imct_pkg::*;
(
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    // Request
    input  wire logic             i_req,
    input  wire imct_pkg::imct_kind_t i_kind,
    input  wire logic             i_write,
    input  wire logic             i_wide,
    input  wire logic [23:0]      i_addr,
    input  wire logic             i_iochrdy,
    output logic                  o_ready,
    output logic                  o_done,
    // Bus pins, active low strobes
    output logic                  o_bclk,
    output logic                  o_ale_n,
    output logic [6:0]            o_la,
    output logic [19:0]           o_sa,
    output logic                  o_memr_n,
    output logic                  o_memw_n,
    output logic                  o_smemr_n,
    output logic                  o_smemw_n,
    output logic                  o_ior_n,
    output logic                  o_iow_n
);
    import imct_pkg::*;

    typedef enum logic [2:0] {
        IMCT_IDLE,
        IMCT_ALE,
        IMCT_SETUP,
        IMCT_CMD,
        IMCT_HOLD
    } imct_state_t;

    function automatic logic [CNT_W-1:0] to_cnt(input int unsigned t);
        to_cnt = CNT_W'(t);
    endfunction

    imct_state_t         state, next_state;
    logic                tick, next_tick;
    logic                bclk, next_bclk;
    logic [CNT_W-1:0]    step_cnt, next_step_cnt;
    logic [CNT_W-1:0]    ale_cnt, next_ale_cnt;
    logic [CNT_W-1:0]    cmd_cnt, next_cmd_cnt;
    logic [CNT_W-1:0]    neg_cnt, next_neg_cnt;
    logic [CNT_W-1:0]    sa_cnt, next_sa_cnt;
    logic                cmd_on, next_cmd_on;
    logic                ale_on, next_ale_on;
    logic                done, next_done;
    imct_kind_t          kind, next_kind;
    logic                wr, next_wr;
    logic [6:0]          la, next_la;
    logic [19:0]         sa, next_sa;
    // Slave width kept per cycle; narrow slaves answer later
    logic                wide, next_wide;

    function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] c);
        dec = (c != '0) ? c - CNT_W'(1) : c;
    endfunction

    // Bus clock strobe: one reference tick per T edge pair
    always_comb begin
        next_tick = ~tick;
        next_bclk = tick ? ~bclk : bclk;
    end

    always_comb begin
        next_state    = state;
        next_step_cnt = step_cnt;
        next_ale_cnt  = ale_cnt;
        next_cmd_cnt  = cmd_cnt;
        next_neg_cnt  = neg_cnt;
        next_sa_cnt   = sa_cnt;
        next_cmd_on   = cmd_on;
        next_ale_on   = ale_on;
        next_done     = 1'b0;
        next_kind     = kind;
        next_wr       = wr;
        next_la       = la;
        next_sa       = sa;
        next_wide     = wide;
        if (tick) begin
            // Counters move once per T
            next_step_cnt = dec(step_cnt);
            next_ale_cnt  = dec(ale_cnt);
            next_cmd_cnt  = dec(cmd_cnt);
            next_neg_cnt  = dec(neg_cnt);
            next_sa_cnt   = dec(sa_cnt);
            case (state)
                IMCT_IDLE: begin
                    // SA is only released after its hold has run out
                    if (i_req && ale_cnt == '0 && sa_cnt == '0) begin
                        next_kind     = i_kind;
                        next_wr       = i_write;
                        next_la       = i_addr[23:17];
                        next_sa       = i_addr[19:0];
                        next_wide     = i_wide;
                        next_ale_on   = 1'b1;
                        next_step_cnt = to_cnt(ALE_WIDTH_T);
                        next_state    = IMCT_ALE;
                    end
                end
                IMCT_ALE: begin
                    if (step_cnt <= 1) begin
                        next_ale_on   = 1'b0;
                        next_step_cnt = to_cnt(ALE_TO_CMD_T - ALE_WIDTH_T);
                        next_state    = IMCT_SETUP;
                    end
                end
                IMCT_SETUP: begin
                    // Wait out command spacing and negation recovery
                    if (step_cnt <= 1 && cmd_cnt <= 1 && neg_cnt <= 1) begin
                        next_cmd_on   = 1'b1;
                        next_cmd_cnt  = to_cnt(CMD_TO_CMD_T);
                        next_ale_cnt  = to_cnt(CMD_TO_ALE_T);
                        next_sa_cnt   = (kind == IMCT_KIND_IO) ? to_cnt(IO_ADDR_HOLD_T)
                                                               : to_cnt(MEM_ADDR_HOLD_T);
                        // Narrow slaves may pull ready late; sample one T past that
                        next_step_cnt = wide ? to_cnt(CMD_WIDTH_T)
                                             : to_cnt(RDY8_FROM_CMD_T + RDY_TO_NEG_T);
                        next_state    = IMCT_CMD;
                    end
                end
                IMCT_CMD: begin
                    // Slave stretch: hold command while ready is low
                    if (step_cnt <= 1 && i_iochrdy) begin
                        next_step_cnt = to_cnt(RDY_TO_NEG_T);
                        next_state    = IMCT_HOLD;
                    end
                end
                IMCT_HOLD: begin
                    if (step_cnt <= 1) begin
                        next_cmd_on  = 1'b0;
                        next_neg_cnt = to_cnt(NEG_TO_CMD_T);
                        // Next ALE never sooner than 1 T after negation
                        if (ale_cnt < to_cnt(NEG_TO_ALE_T + 1)) begin
                            next_ale_cnt = to_cnt(NEG_TO_ALE_T);
                        end
                        next_done    = 1'b1;
                        next_state   = IMCT_IDLE;
                    end
                end
                default: next_state = IMCT_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state    <= IMCT_IDLE;
            tick     <= 1'b0;
            bclk     <= 1'b0;
            step_cnt <= '0;
            ale_cnt  <= '0;
            cmd_cnt  <= '0;
            neg_cnt  <= '0;
            sa_cnt   <= '0;
            cmd_on   <= 1'b0;
            ale_on   <= 1'b0;
            done     <= 1'b0;
            kind     <= IMCT_KIND_MEM;
            wr       <= 1'b0;
            la       <= LA_RESET;
            sa       <= SA_RESET;
            wide     <= 1'b1;
        end else begin
            state    <= next_state;
            tick     <= next_tick;
            bclk     <= next_bclk;
            step_cnt <= next_step_cnt;
            ale_cnt  <= next_ale_cnt;
            cmd_cnt  <= next_cmd_cnt;
            neg_cnt  <= next_neg_cnt;
            sa_cnt   <= next_sa_cnt;
            cmd_on   <= next_cmd_on;
            ale_on   <= next_ale_on;
            done     <= next_done;
            kind     <= next_kind;
            wr       <= next_wr;
            la       <= next_la;
            sa       <= next_sa;
            wide     <= next_wide;
        end
    end

    assign o_ready   = (state == IMCT_IDLE) && tick && ale_cnt == '0 && sa_cnt == '0;
    assign o_done    = done;
    assign o_bclk    = bclk;
    assign o_ale_n   = ~ale_on;
    assign o_la      = la;
    assign o_sa      = sa;
    assign o_memr_n  = ~(cmd_on && kind == IMCT_KIND_MEM && !wr);
    assign o_memw_n  = ~(cmd_on && kind == IMCT_KIND_MEM && wr);
    assign o_smemr_n = ~(cmd_on && kind == IMCT_KIND_SMEM && !wr);
    assign o_smemw_n = ~(cmd_on && kind == IMCT_KIND_SMEM && wr);
    assign o_ior_n   = ~(cmd_on && kind == IMCT_KIND_IO && !wr);
    assign o_iow_n   = ~(cmd_on && kind == IMCT_KIND_IO && wr);

    // Checks, counted in reference clocks
    logic [7:0] since_cmd;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) since_cmd <= 8'hFF;
        else if (cmd_on && !$past(cmd_on)) since_cmd <= 8'h01;
        else if (since_cmd != 8'hFF) since_cmd <= since_cmd + 8'h01;
    end

    cmd_spacing_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(cmd_on) |-> since_cmd >= 8'(CMD_TO_CMD_T * TICKS_PER_T))
        else $error("command assertions too close");

    ale_after_cmd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(ale_on) |-> since_cmd >= 8'(CMD_TO_ALE_T * TICKS_PER_T))
        else $error("ale too soon after command");

    neg_to_cmd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(cmd_on) |=> !cmd_on [*5])
        else $error("command reasserted too soon");

    neg_to_ale_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(cmd_on) |-> !ale_on ##1 !ale_on)
        else $error("ale too soon after negation");

    ale_width_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(ale_on) |-> ale_on [*2])
        else $error("ale pulse too short");

    sa_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (!$stable(sa) && $past(kind) != IMCT_KIND_IO) |-> since_cmd >= 8'(MEM_ADDR_HOLD_T * TICKS_PER_T))
        else $error("address changed after command");

    stretch_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == IMCT_CMD && !i_iochrdy) |=> cmd_on)
        else $error("command dropped while slave not ready");

    cmd_width_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(cmd_on) |-> cmd_on [*8])
        else $error("command shorter than ready window");

    io_sa_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (!$stable(sa) && $past(kind) == IMCT_KIND_IO) |-> since_cmd >= 8'(IO_ADDR_HOLD_T * TICKS_PER_T))
        else $error("address changed inside io hold");

    // Ready is judged only once the slave's window has passed
    ready_wait_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(cmd_on) |-> since_cmd > 8'((wide ? RDY16_FROM_CMD_T : RDY8_FROM_CMD_T) * TICKS_PER_T))
        else $error("ready sampled inside slave window");

    // Counts saturate, so a long idle reads as far apart
    logic [7:0] since_la;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) since_la <= 8'hFF;
        else if (ale_on && !$past(ale_on)) since_la <= 8'h01;
        else if (since_la != 8'hFF) since_la <= since_la + 8'h01;
    end

    la_ready_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(cmd_on) |-> since_la > 8'((wide ? RDY16_FROM_LA_T : RDY8_FROM_LA_T) * TICKS_PER_T))
        else $error("ready sampled too soon after upper address");

    la_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !$stable(la) |-> $rose(ale_on))
        else $error("upper address moved without ale");

    cmd_after_ale_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(cmd_on) |-> !ale_on)
        else $error("command asserted while ale still on");

    stall_end_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(cmd_on) |-> $past(i_iochrdy, 3))
        else $error("command ended without slave ready");

    done_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(cmd_on) |-> done)
        else $error("done missing at command end");

    bclk_toggle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        tick |=> !$stable(bclk))
        else $error("bus clock missed a half period");

endmodule
`default_nettype wire

// ==== verification/imct_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module imct_slave_model (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Bus side
    input  wire logic       i_cmd_n,
    input  wire logic       i_wide,
    input  wire logic [7:0] i_stall,
    output logic            o_iochrdy
);
    logic [7:0] cnt;
    logic [7:0] lead;
    // Narrow slaves pull ready later; the master waits past that point
    assign lead = i_wide ? 8'h0C : 8'h18;
    // Pulled up, so released means ready
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_cmd_n) begin
            cnt       <= 8'h00;
            o_iochrdy <= 1'b1;
        end else begin
            cnt       <= cnt + 8'h01;
            o_iochrdy <= !(cnt >= lead && cnt < lead + i_stall);
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import imct_pkg::*;
    localparam int TK = TICKS_PER_T;
    logic        i_ref_clk, i_rst_n, i_req, i_write, i_wide, i_iochrdy;
    imct_kind_t  i_kind;
    logic [23:0] i_addr;
    logic [7:0]  stall;
    logic        o_ready, o_done, o_bclk, o_ale_n, o_memr_n, o_memw_n;
    logic        o_smemr_n, o_smemw_n, o_ior_n, o_iow_n, last_io, p_cmd, p_ale, p_bclk;
    logic [6:0]  o_la;
    logic [19:0] o_sa, p_sa;
    logic [5:0]  cmds, seen;
    int          num_errors = 0, n_tests = 0, cyc = 0;
    int          c_fall, c_rise, a_fall, b_rise;
    assign cmds = {o_memr_n, o_memw_n, o_smemr_n, o_smemw_n, o_ior_n, o_iow_n};
    imct_cycle_timer imct_cycle_timer_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(i_req),
        .i_kind(i_kind), .i_write(i_write), .i_wide(i_wide), .i_addr(i_addr), .i_iochrdy(i_iochrdy),
        .o_ready(o_ready), .o_done(o_done), .o_bclk(o_bclk), .o_ale_n(o_ale_n), .o_la(o_la),
        .o_sa(o_sa), .o_memr_n(o_memr_n), .o_memw_n(o_memw_n), .o_smemr_n(o_smemr_n),
        .o_smemw_n(o_smemw_n), .o_ior_n(o_ior_n), .o_iow_n(o_iow_n));
    imct_slave_model imct_slave_model_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cmd_n(&cmds),
        .i_wide(i_wide), .i_stall(stall), .o_iochrdy(i_iochrdy));
    task automatic chk_min(input string n, input int got, input int lo);
        n_tests++;
        if (got < lo) begin
            num_errors++;
            $display("Error %s expected at least %0d seen %0d", n, lo, got);
        end
    endtask
    task automatic chk_eq(input string n, input logic [34:0] exp, input logic [34:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Spacing watcher; bus figures are minima, judged as lower bounds; the bclk period is checked exactly
    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
            num_errors++;
            tally_and_finish();
        end
        if (!i_rst_n) begin
            c_fall = -999;
            c_rise = -999;
            a_fall = -999;
            b_rise = -1;
            last_io = 1'b0;
        end else begin
            seen = seen | ~cmds;
            if (p_cmd && !(&cmds)) begin
                chk_min("cmd spacing", cyc - c_fall, TK * CMD_TO_CMD_T);
                chk_min("neg to cmd", cyc - c_rise, TK * NEG_TO_CMD_T);
                c_fall = cyc;
                last_io = !(o_ior_n && o_iow_n);
            end
            if (!p_cmd && (&cmds)) c_rise = cyc;
            if (p_ale && !o_ale_n) begin
                chk_min("cmd to ale", cyc - c_fall, TK * CMD_TO_ALE_T);
                chk_min("neg to ale", cyc - c_rise, TK * NEG_TO_ALE_T);
                a_fall = cyc;
            end
            if (!p_ale && o_ale_n) chk_min("ale width", cyc - a_fall, TK * ALE_WIDTH_T);
            if (o_sa !== p_sa) chk_min("sa hold", cyc - c_fall,
                TK * (last_io ? IO_ADDR_HOLD_T : MEM_ADDR_HOLD_T));
            if (o_bclk && !p_bclk) begin
                if (b_rise >= 0) chk_eq("bclk period", 35'(2 * TK), 35'(cyc - b_rise));
                b_rise = cyc;
            end
        end
        p_cmd = &cmds;
        p_ale = o_ale_n;
        p_sa = o_sa;
        p_bclk = o_bclk;
    end
    task automatic start(input imct_kind_t k, input logic w, input logic [23:0] a);
        int n;
        @(negedge i_ref_clk);
        i_req = 1'b1;
        i_kind = k;
        i_write = w;
        i_addr = a;
        n = 0;
        while (o_ready !== 1'b1 && n < 300) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk_min("ready wait", 300 - n, 1);
        @(negedge i_ref_clk);
        i_req = 1'b0;
        seen = 6'h00;
    endtask
    task automatic xfer(input imct_kind_t k, input logic w, input logic [23:0] a);
        int n;
        start(k, w, a);
        n = 0;
        while (o_done !== 1'b1 && n < 300) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk_min("done wait", 300 - n, 1);
        chk_eq("strobe used", 35'(6'h20 >> (2 * int'(k) + w)), 35'(seen));
        chk_eq("la sa", 35'({a[23:17], a[19:0]}), 35'({o_la, o_sa}));
    endtask
    // Back to back, every command kind and direction, both slave widths
    task automatic t_kinds;
        for (int j = 0; j < 6; j++) begin
            i_wide = j[0];
            xfer(imct_kind_t'(j / 2), j[0], {2'(j / 2), j[0], 1'b0, 2'(j / 2), j[0], 17'h0A5A5});
        end
        $display("t_kinds finished");
    endtask
    // Slave stretches a 16-bit cycle and then an 8-bit cycle; command must outlast the stall
    task automatic t_stall;
        i_wide = 1'b1;
        stall = 8'h28;
        xfer(IMCT_KIND_MEM, 1'b0, 24'h3C0F0F);
        @(negedge i_ref_clk);
        chk_min("stalled width", c_rise - c_fall, TK * RDY16_FROM_CMD_T + 40);
        i_wide = 1'b0;
        xfer(IMCT_KIND_MEM, 1'b1, 24'h0C3F00);
        @(negedge i_ref_clk);
        chk_min("narrow stalled width", c_rise - c_fall, TK * RDY8_FROM_CMD_T + 40);
        i_wide = 1'b1;
        stall = 8'h00;
        $display("t_stall finished");
    endtask
    // Reset in mid-cycle must drop every strobe at once
    task automatic t_reset;
        start(IMCT_KIND_IO, 1'b1, 24'h5A5A5A);
        repeat (8) @(negedge i_ref_clk);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        chk_eq("reset pins", {1'b1, 6'h3F, 1'b0, LA_RESET, SA_RESET}, {o_ale_n, cmds, o_done, o_la, o_sa});
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        xfer(IMCT_KIND_SMEM, 1'b1, 24'h81E001);
        $display("t_reset finished");
    endtask
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        i_rst_n = 1'b0;
        i_req = 1'b0;
        i_kind = IMCT_KIND_MEM;
        i_write = 1'b0;
        i_wide = 1'b1;
        i_addr = 24'h000000;
        stall = 8'h00;
        repeat (16) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        t_kinds();
        t_stall();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
